// file: hw/secc_core.sv
// How it works
// - Status read repeats status byte until deselect.
// - Status readable anytime; live latch and busy.
// - Status bits seven to four read one.
// - Status write changes only protect-select bits.
// - Status write needs latch set first.
// - Select rising edge starts internal write.
// - Busy during write; latch cleared at end.
// - New protect bits apply at cycle end.
// - Status write needs exactly sixteen clocks.
// - Read loads address counter, streams bytes.
// - Read address wraps top to zero.
// - Read ignored while busy; deselect ends read.
// - Opcode bit three carries address bit eight.
// - Page write: low four bits wrap.
// - Memory write rejected: no latch, busy, pin low, protected, bad length.
// - Memory write needs sixteen plus eight per byte.
// - Protect bits select none, quarter, half, all.
// - Protect pin low blocks writes, clears latch.
// - Hold floats output, ignores clock and input.
// - Hold switches now, or at falling edge.
// - Reset or low supply aborts write, clears latch.
// - Control opcodes one byte, MSB first.
// - Read and write opcodes take one address byte.
// - Sample on rising edge, drive on falling.
// - Bad opcode ignores rest of frame.
`timescale 1ns/1ps
`default_nettype none

module secc_core #(
  parameter int ADDR_W       = secc_pkg::ADDR_W,
  parameter int PAGE_BYTES   = secc_pkg::PAGE_BYTES,
  parameter int WRITE_CYCLES = secc_pkg::WRITE_CYCLES
) (
  // System clock and power-on reset.
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  // Low supply detector, high while supply is low.
  input  wire logic       i_low_supply,
  // Serial link from the host.
  input  wire logic       i_sck,
  input  wire logic       i_cs_n,
  input  wire logic       i_si,
  input  wire logic       i_hold_n,
  input  wire logic       i_wp_n,
  // Serial data output pin.
  output logic            o_so,
  output logic            o_so_oe,
  // Status byte as held in the system domain.
  output logic [7:0]      o_status
);

  // -----------------------------------------------------------------
  // Local sizes and types
  // -----------------------------------------------------------------
  localparam int COL_W = $clog2(PAGE_BYTES);
  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int HI_W  = ADDR_W - COL_W;

  typedef enum logic [2:0] {
    ST_OPC, ST_ADDR, ST_SRD, ST_SWR, ST_RD, ST_WR, ST_WAIT
  } secc_state_t;

  // Decode the first byte; bit three never takes part in the choice.
  function automatic secc_pkg::secc_cmd_t f_decode(input logic [7:0] b);
    f_decode = secc_pkg::CMD_BAD;
    if (b[7:4] == secc_pkg::OPC_TOP) begin
      case (b[2:0])
        secc_pkg::OPC_SET: f_decode = secc_pkg::CMD_SET;
        secc_pkg::OPC_CLR: f_decode = secc_pkg::CMD_CLR;
        secc_pkg::OPC_SRD: f_decode = secc_pkg::CMD_SRD;
        secc_pkg::OPC_SWR: f_decode = secc_pkg::CMD_SWR;
        secc_pkg::OPC_RD:  f_decode = secc_pkg::CMD_RD;
        secc_pkg::OPC_WR:  f_decode = secc_pkg::CMD_WR;
        default:           f_decode = secc_pkg::CMD_BAD;
      endcase
    end
  endfunction

  // Protected region as a fraction of the top of the array.
  function automatic logic f_protected(input logic [ADDR_W-1:0] a,
                                       input logic [1:0]        bp);
    case (bp)
      secc_pkg::PROT_NONE: f_protected = 1'b0;
      secc_pkg::PROT_QTR:  f_protected = &a[ADDR_W-1 -: 2];
      secc_pkg::PROT_HALF: f_protected = a[ADDR_W-1];
      default:             f_protected = 1'b1;
    endcase
  endfunction

  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  logic [7:0]              mem [0:DEPTH-1];

  logic                    frm_rst_n;
  logic                    frm_act;
  logic                    frm_tog;
  secc_state_t             state;
  secc_state_t             next_state;
  logic [2:0]              bit_cnt;
  logic [5:0]              byte_cnt;
  logic [2:0]              cur_bit;
  logic [5:0]              cur_bytes;
  logic [2:0]              next_bit;
  logic [5:0]              next_bytes;
  logic                    byte_done;
  logic [6:0]              sh;
  logic [7:0]              rx_byte;
  secc_pkg::secc_cmd_t     opc_cmd;
  secc_pkg::secc_cmd_t     f_cmd;
  logic                    f_a8;
  logic [ADDR_W-1:0]       addr_rx;
  logic [ADDR_W-1:0]       f_addr;
  logic [7:0]              f_sdata;
  logic [ADDR_W-1:0]       rd_addr;
  logic [8*PAGE_BYTES-1:0] wr_buf;
  logic [PAGE_BYTES-1:0]   wr_mask;
  logic [COL_W-1:0]        wr_col;
  logic [3:0]              st_live;
  logic [3:0]              st_s;
  logic                    busy_s;
  logic                    hold_hi;
  logic                    hold_now;
  logic                    tx_state;
  logic                    tx_load;
  logic [7:0]              tx_byte;
  logic [7:0]              out_sh;
  logic                    tx_on;

  logic                    cs_q;
  logic                    low_q;
  logic                    wp_q;
  logic                    cs_prev;
  logic                    cs_rise;
  logic                    seen_tog;
  logic                    new_frm;
  logic                    on_byte;
  logic                    prot_hit;
  logic                    ev_set;
  logic                    ev_clr;
  logic                    ev_swr;
  logic                    ev_mwr;
  logic                    wr_start;
  logic                    wdone;
  logic                    latch;
  logic                    next_latch;
  logic                    busy;
  logic                    next_busy;
  logic [CNT_W-1:0]        wcnt;
  logic [CNT_W-1:0]        next_wcnt;
  logic [1:0]              prot;
  logic                    pend_mem;
  logic [1:0]              pend_bp;
  logic [8*PAGE_BYTES-1:0] hbuf;
  logic [PAGE_BYTES-1:0]   hmask;
  logic [HI_W-1:0]         hbase;

  // -----------------------------------------------------------------
  // Link side: bit and byte counting
  // -----------------------------------------------------------------

  // Deselect clears the frame state at once, even with the clock stopped.
  assign frm_rst_n = i_reset_n & ~i_cs_n;

  // Counters restart on the first edge of a frame, so they stay readable
  // by the system side after deselect.
  assign cur_bit    = frm_act ? bit_cnt : 3'h0;
  assign cur_bytes  = frm_act ? byte_cnt : 6'h00;
  assign byte_done  = (cur_bit == 3'h7);
  assign next_bit   = cur_bit + 3'h1;
  assign next_bytes = !byte_done ? cur_bytes :
                      (cur_bytes == secc_pkg::LEN_MAX) ? cur_bytes :
                      cur_bytes + 6'h01;
  assign rx_byte    = {frm_act ? sh : 7'h00, i_si};
  assign opc_cmd    = f_decode(rx_byte);
  assign addr_rx    = ADDR_W'({f_a8 & (ADDR_W > 8), rx_byte});

  // Frame sequencer; only a completed byte moves it.
  always_comb begin
    next_state = state;
    if (byte_done) begin
      case (state)
        ST_OPC: begin
          case (opc_cmd)
            secc_pkg::CMD_SRD: next_state = ST_SRD;
            secc_pkg::CMD_SWR: next_state = ST_SWR;
            secc_pkg::CMD_RD:  next_state = busy_s ? ST_WAIT : ST_ADDR;
            secc_pkg::CMD_WR:  next_state = ST_ADDR;
            default:           next_state = ST_WAIT;
          endcase
        end
        ST_ADDR: next_state = (f_cmd == secc_pkg::CMD_RD) ? ST_RD : ST_WR;
        ST_SWR:  next_state = ST_WAIT;
        default: next_state = state;
      endcase
    end
  end

  // Frame control, cleared by deselect. Hold freezes it.
  always_ff @(posedge i_sck or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      frm_act <= 1'b0;
      state   <= ST_OPC;
    end else if (i_hold_n) begin
      frm_act <= 1'b1;
      state   <= next_state;
    end
  end

  // Shift register and counters sample on the rising edge.
  always_ff @(posedge i_sck or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 6'h00;
      sh       <= 7'h00;
      frm_tog  <= 1'b0;
    end else if (i_hold_n) begin
      bit_cnt  <= next_bit;
      byte_cnt <= next_bytes;
      sh       <= rx_byte[6:0];
      frm_tog  <= frm_tog ^ ~frm_act;
    end
  end

  // Hold state as of the last rising edge, used while the clock is high.
  always_ff @(posedge i_sck or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hold_hi <= 1'b0;
    end else begin
      hold_hi <= ~i_hold_n;
    end
  end

  // Clock low: the pin acts at once. Clock high: the change waits for
  // the falling edge, when the clock low path takes over.
  assign hold_now = i_sck ? hold_hi : ~i_hold_n;

  // -----------------------------------------------------------------
  // Link side: captured command, address and page data
  // -----------------------------------------------------------------
  always_ff @(posedge i_sck or negedge i_reset_n) begin
    if (!i_reset_n) begin
      f_cmd   <= secc_pkg::CMD_NONE;
      f_a8    <= 1'b0;
      f_addr  <= '0;
      f_sdata <= 8'h00;
      rd_addr <= '0;
    end else if (i_hold_n && byte_done) begin
      if (state == ST_OPC) begin
        f_cmd <= opc_cmd;
        f_a8  <= rx_byte[secc_pkg::OPC_A8];
      end
      if (state == ST_ADDR) begin
        f_addr  <= addr_rx;
        rd_addr <= addr_rx;
      end
      if (state == ST_RD) begin
        rd_addr <= rd_addr + 1'b1;
      end
      if (state == ST_SWR) begin
        f_sdata <= rx_byte;
      end
    end
  end

  // Page buffer; the column counter wraps inside one page.
  always_ff @(posedge i_sck or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_buf  <= '0;
      wr_mask <= '0;
      wr_col  <= '0;
    end else if (i_hold_n && byte_done && state == ST_ADDR) begin
      wr_mask <= '0;
      wr_col  <= addr_rx[COL_W-1:0];
    end else if (i_hold_n && byte_done && state == ST_WR) begin
      wr_buf[wr_col*8 +: 8] <= rx_byte;
      wr_mask[wr_col]       <= 1'b1;
      wr_col                <= wr_col + 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // Link side: output shifter on the falling edge
  // -----------------------------------------------------------------

  // Status bits cross into the link clock; they settle within the opcode.
  assign st_live = {prot, latch, busy};

  secc_sync #(
    .W   (4),
    .RST (4'h0)
  ) u_st_sync (
    .i_clk     (i_sck),
    .i_reset_n (i_reset_n),
    .i_async   (st_live),
    .o_level   (st_s)
  );

  assign busy_s   = st_s[secc_pkg::SR_BUSY];
  assign tx_state = (state == ST_SRD) || (state == ST_RD);
  assign tx_load  = tx_state && frm_act && (bit_cnt == 3'h0);
  assign tx_byte  = (state == ST_SRD) ?
                    {secc_pkg::SR_ONES, st_s} :
                    mem[rd_addr];

  // Reloading at every byte boundary repeats the status byte.
  always_ff @(negedge i_sck or negedge i_reset_n) begin
    if (!i_reset_n) begin
      out_sh <= 8'h00;
    end else if (i_hold_n && tx_load) begin
      out_sh <= tx_byte;
    end else if (i_hold_n) begin
      out_sh <= {out_sh[6:0], 1'b0};
    end
  end

  // Drive enable arms with the first loaded bit and falls with deselect.
  always_ff @(negedge i_sck or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      tx_on <= 1'b0;
    end else if (i_hold_n && tx_load) begin
      tx_on <= 1'b1;
    end
  end

  assign o_so    = out_sh[7];
  assign o_so_oe = tx_on & ~hold_now;

  // -----------------------------------------------------------------
  // System side: pin filters and frame commit
  // -----------------------------------------------------------------
  secc_sync #(
    .W   (3),
    .RST (3'h5)
  ) u_pin_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   ({i_cs_n, i_low_supply, i_wp_n}),
    .o_level   ({cs_q, low_q, wp_q})
  );

  // Link registers are read only after deselect, when the link clock
  // is quiet; an empty frame is told apart by the frame toggle.
  assign cs_rise  = cs_q & ~cs_prev;
  assign new_frm  = frm_tog ^ seen_tog;
  assign on_byte  = (bit_cnt == 3'h0) & cs_rise & new_frm;
  assign prot_hit = f_protected(f_addr, prot);

  assign ev_set = on_byte && (f_cmd == secc_pkg::CMD_SET) &&
                  (byte_cnt == secc_pkg::LEN_LATCH);
  assign ev_clr = on_byte && (f_cmd == secc_pkg::CMD_CLR) &&
                  (byte_cnt == secc_pkg::LEN_LATCH);
  assign ev_swr = on_byte && (f_cmd == secc_pkg::CMD_SWR) &&
                  (byte_cnt == secc_pkg::LEN_SWR) &&
                  latch && !busy && wp_q;
  assign ev_mwr = on_byte && (f_cmd == secc_pkg::CMD_WR) &&
                  (byte_cnt >= secc_pkg::LEN_WMIN) &&
                  latch && !busy && wp_q && !prot_hit;
  assign wr_start = ev_swr | ev_mwr;

  // -----------------------------------------------------------------
  // System side: write cycle and status
  // -----------------------------------------------------------------

  // Low supply aborts with no commit; the cycle count is a parameter.
  assign wdone     = busy && (wcnt == '0) && !low_q;
  assign next_busy = low_q    ? 1'b0 :
                     wr_start ? 1'b1 :
                     wdone    ? 1'b0 : busy;
  assign next_wcnt = wr_start ? CNT_W'(WRITE_CYCLES - 1) :
                     (busy && wcnt != '0) ? wcnt - 1'b1 : wcnt;

  // Pin and supply clears beat a set; a set beats the end-of-cycle clear.
  assign next_latch = (low_q || !wp_q) ? 1'b0 :
                      ev_set           ? 1'b1 :
                      (ev_clr || wdone) ? 1'b0 : latch;

  // Status and write-cycle control.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cs_prev  <= 1'b1;
      seen_tog <= 1'b0;
      latch    <= 1'b0;
      busy     <= 1'b0;
      wcnt     <= '0;
      prot     <= secc_pkg::PROT_RESET;
      pend_mem <= 1'b0;
      pend_bp  <= secc_pkg::PROT_RESET;
    end else begin
      cs_prev <= cs_q;
      latch   <= next_latch;
      busy    <= next_busy;
      wcnt    <= next_wcnt;
      if (cs_rise) begin
        seen_tog <= frm_tog;
      end
      if (wr_start) begin
        pend_mem <= ev_mwr;
        pend_bp  <= f_sdata[secc_pkg::SR_PHI:secc_pkg::SR_PLO];
      end
      if (wdone && !pend_mem) begin
        prot <= pend_bp;
      end
    end
  end

  // Page copy taken at the start, so a later frame cannot disturb it.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hbuf  <= '0;
      hmask <= '0;
      hbase <= '0;
    end else if (ev_mwr) begin
      hbuf  <= wr_buf;
      hmask <= wr_mask;
      hbase <= f_addr[ADDR_W-1:COL_W];
    end
  end

  // Array update at the end of the cycle; the array has no reset.
  always_ff @(posedge i_clk) begin
    if (wdone && pend_mem) begin
      for (int k = 0; k < PAGE_BYTES; k++) begin
        if (hmask[k]) begin
          mem[{hbase, COL_W'(k)}] <= hbuf[k*8 +: 8];
        end
      end
    end
  end

  assign o_status = {secc_pkg::SR_ONES, prot, latch, busy};

endmodule // secc_core

`default_nettype wire

// file: hw/secc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module secc_sync #(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  // Destination clock and reset.
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  // Asynchronous levels in, filtered levels out.
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level
);

  logic [W-1:0] meta;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] agree;

  // A bit moves only once two settled stages match, so a blip is dropped.
  assign agree = ~(stage2 ^ stage3);

  // Three stages, then the agreement filter.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta    <= RST;
      stage2  <= RST;
      stage3  <= RST;
      o_level <= RST;
    end else begin
      meta    <= i_async;
      stage2  <= meta;
      stage3  <= stage2;
      o_level <= (agree & stage3) | (~agree & o_level);
    end
  end

endmodule // secc_sync

`default_nettype wire

// file: inc/secc_pkg.sv
`default_nettype none

package secc_pkg;

  // -----------------------------------------------------------------
  // Opcode layout: upper nibble must be zero, low three bits select.
  // -----------------------------------------------------------------
  localparam logic [3:0] OPC_TOP  = 4'h0;
  localparam logic [2:0] OPC_SET  = 3'h6;
  localparam logic [2:0] OPC_CLR  = 3'h4;
  localparam logic [2:0] OPC_SRD  = 3'h5;
  localparam logic [2:0] OPC_SWR  = 3'h1;
  localparam logic [2:0] OPC_RD   = 3'h3;
  localparam logic [2:0] OPC_WR   = 3'h2;
  localparam int         OPC_A8   = 3;

  // -----------------------------------------------------------------
  // Status byte layout.
  // -----------------------------------------------------------------
  localparam logic [3:0] SR_ONES  = 4'hF;
  localparam int         SR_BUSY  = 0;
  localparam int         SR_LATCH = 1;
  localparam int         SR_PLO   = 2;
  localparam int         SR_PHI   = 3;

  // Protect-select encodings.
  localparam logic [1:0] PROT_NONE  = 2'h0;
  localparam logic [1:0] PROT_QTR   = 2'h1;
  localparam logic [1:0] PROT_HALF  = 2'h2;
  localparam logic [1:0] PROT_RESET = 2'h0;

  // -----------------------------------------------------------------
  // Frame lengths, counted in whole bytes.
  // -----------------------------------------------------------------
  localparam logic [5:0] LEN_LATCH = 6'h01;
  localparam logic [5:0] LEN_SWR   = 6'h02;
  localparam logic [5:0] LEN_WMIN  = 6'h03;
  localparam logic [5:0] LEN_MAX   = 6'h3F;

  // -----------------------------------------------------------------
  // Array geometry and write timing.
  // -----------------------------------------------------------------
  localparam int ADDR_W        = 9;
  localparam int PAGE_BYTES    = 16;
  localparam int CLK_PERIOD_NS = 25;
  localparam int WRITE_TIME_NS = 100000;
  localparam int WRITE_CYCLES  =
    (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Commands as decoded from the first byte of a frame.
  typedef enum logic [2:0] {
    CMD_NONE, CMD_SET, CMD_CLR, CMD_SRD, CMD_SWR, CMD_RD, CMD_WR, CMD_BAD
  } secc_cmd_t;

endpackage

`default_nettype wire

// file: tb/secc_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Port checker for the command core.
// ---------------------------------------------------------------
module secc_core_sva #(
  parameter int WRITE_CYCLES = 8
) (
  // Watched ports.
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  input wire logic       i_low_supply,
  input wire logic       i_sck,
  input wire logic       i_cs_n,
  input wire logic       i_hold_n,
  input wire logic       i_wp_n,
  input wire logic       o_so_oe,
  input wire logic [7:0] o_status
);
  int busy_cnt;
  // Counts busy cycles so the write length can be compared exactly.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) busy_cnt <= 0;
    else busy_cnt <= o_status[0] ? busy_cnt + 1 : 0;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  ones_high_a: assert property (o_status[7:4] == 4'hF)
    else $error("upper status bits not one");
  busy_len_a: assert property ($fell(o_status[0]) && !i_low_supply |->
    busy_cnt == WRITE_CYCLES)
    else $error("busy length wrong");
  latch_end_a: assert property ($fell(o_status[0]) |-> ##[0:1] !o_status[1])
    else $error("latch kept after write");
  wp_latch_a: assert property ((!i_wp_n)[*6] |-> !o_status[1])
    else $error("latch set with protect pin low");
  low_sup_a: assert property (i_low_supply[*6] |-> o_status[1:0] == 2'h0)
    else $error("low supply did not abort");
  prot_commit_a: assert property ($changed(o_status[3:2]) |-> $fell(o_status[0]))
    else $error("protect bits changed mid cycle");
  oe_desel_a: assert property (i_cs_n && $past(i_cs_n) |-> !o_so_oe)
    else $error("output driven while deselected");
  hold_float_a: assert property (!i_hold_n && !i_sck |-> !o_so_oe)
    else $error("output driven in hold");
  busy_start_a: assert property ($rose(o_status[0]) |->
    $past(i_cs_n, 3) && o_status[1])
    else $error("write started without latch or select");
endmodule // secc_core_sva
bind secc_core secc_core_sva #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_low_supply(i_low_supply), .i_sck(i_sck),
  .i_cs_n(i_cs_n), .i_hold_n(i_hold_n), .i_wp_n(i_wp_n), .o_so_oe(o_so_oe),
  .o_status(o_status));
`default_nettype wire

// file: tb/secc_core_test.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Self-checking bench for the command core.
// ---------------------------------------------------------------
module secc_core_test;
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        low = 1'b0;
  logic        hold_n = 1'b1;
  logic        wp_n = 1'b1;
  logic        oe_seen = 1'b0;
  logic [63:0] rx;
  wire         sck, cs_n, si, so, so_oe;
  wire  [7:0]  status;
  int          n_mismatch = 0;
  int          checks_done = 0;
  // A long write cycle so a status read fits inside it.
  always #12.5 i_clk = ~i_clk;
  always @(posedge so_oe) oe_seen = 1'b1;
  secc_core #(.WRITE_CYCLES(200)) dut_u (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_low_supply(low), .i_sck(sck),
    .i_cs_n(cs_n), .i_si(si), .i_hold_n(hold_n), .i_wp_n(wp_n), .o_so(so),
    .o_so_oe(so_oe), .o_status(status));
  secc_host host_u (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so));
  task wrap_up;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits for the write cycle to end, with a bound.
  task idle;
    int k;
    for (k = 0; k < 400 && status[0] !== 1'b0; k++) @(posedge i_clk);
    if (k == 400) begin
      n_mismatch++;
      $display("FAIL %0t busy never ended", $time);
      wrap_up();
    end
  endtask
  task status_read_cmd(input logic [7:0] exp);
    host_u.xfer({8'h05, 56'h0}, 24, rx);
    chk(rx[15:0], {exp, exp});
  endtask
  task latch_set_cmd;
    host_u.xfer({8'h06, 56'h0}, 8, rx);
  endtask
  task t_status;
    status_read_cmd(8'hF0);
    host_u.xfer({8'h16, 56'h0}, 8, rx);
    status_read_cmd(8'hF0);
    host_u.xfer({8'h01, 8'h0C, 48'h0}, 16, rx);
    status_read_cmd(8'hF0);
    latch_set_cmd();
    status_read_cmd(8'hF2);
    host_u.xfer({8'h0C, 56'h0}, 8, rx);
    status_read_cmd(8'hF0);
    latch_set_cmd();
    host_u.xfer({8'h01, 8'h0C, 48'h0}, 17, rx);
    chk({8'h00, status}, 16'h00F2);
  endtask
  task t_swr;
    host_u.xfer({8'h01, 8'hFF, 48'h0}, 16, rx);
    status_read_cmd(8'hF3);
    idle();
    status_read_cmd(8'hFC);
    latch_set_cmd();
    host_u.xfer({8'h01, 8'h04, 48'h0}, 16, rx);
    idle();
    status_read_cmd(8'hF4);
  endtask
  task t_mem;
    latch_set_cmd();
    host_u.xfer({8'h0A, 8'hF0, 8'h5A, 40'h0}, 24, rx);
    chk({8'h00, status}, 16'h00F6);
    host_u.xfer({8'h0A, 8'h00, 8'h5A, 40'h0}, 31, rx);
    chk({8'h00, status}, 16'h00F6);
    host_u.xfer({8'h0A, 8'h0E, 8'hAA, 8'h55, 8'hC3, 24'h0}, 40, rx);
    oe_seen = 1'b0;
    host_u.xfer({8'h0B, 8'h0E, 48'h0}, 24, rx);
    chk({15'h0000, oe_seen}, 16'h0000);
    idle();
    host_u.xfer({8'h0B, 8'h0E, 48'h0}, 32, rx);
    chk(rx[15:0], 16'hAA55);
    host_u.xfer({8'h0B, 8'h00, 48'h0}, 24, rx);
    chk({8'h00, rx[7:0]}, 16'h00C3);
  endtask
  task t_guard;
    latch_set_cmd();
    @(negedge i_clk) wp_n = 1'b0;
    repeat (8) @(negedge i_clk);
    chk({8'h00, status}, 16'h00F4);
    wp_n = 1'b1;
    latch_set_cmd();
    host_u.xfer({8'h0A, 8'h00, 8'h11, 40'h0}, 24, rx);
    @(negedge i_clk) low = 1'b1;
    repeat (10) @(negedge i_clk);
    chk({8'h00, status}, 16'h00F4);
    low = 1'b0;
    repeat (8) @(negedge i_clk);
    latch_set_cmd();
    status_read_cmd(8'hF6);
  endtask
  task t_hold;
    fork
      host_u.xfer({8'h05, 56'h0}, 24, rx);
      begin
        #2000;
        @(negedge sck);
        @(negedge i_clk);
        chk({15'h0000, so_oe}, 16'h0001);
        hold_n = 1'b0;
        @(negedge i_clk);
        chk({15'h0000, so_oe}, 16'h0000);
        repeat (10) @(negedge i_clk);
        hold_n = 1'b1;
      end
    join
  endtask
  // Main sequence: reset for ten cycles, then each scenario in turn.
  initial begin
    repeat (10) @(negedge i_clk);
    i_reset_n = 1'b1;
    repeat (6) @(negedge i_clk);
    t_status();
    t_swr();
    t_mem();
    t_guard();
    t_hold();
    wrap_up();
  end
endmodule // secc_core_test
`default_nettype wire

// file: tb/secc_host.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Host model: mode 0 frames, serial clock still between frames.
// ---------------------------------------------------------------
module secc_host (
  // Serial link to the device.
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_si,
  input  wire logic i_so
);
  // Idle levels at time zero.
  initial begin
    o_sck  = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b1;
  end
  // Sends n bits of tx MSB first and samples the reply on each rising edge.
  task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = '0;
    o_cs_n = 1'b0;
    #60;
    for (int i = 0; i < n; i++) begin
      o_si = tx[63-i];
      #62.5 o_sck = 1'b1;
      rx = {rx[62:0], i_so};
      #62.5 o_sck = 1'b0;
    end
    #30 o_cs_n = 1'b1;
    o_si = ~o_si; // A released line must not keep its last value.
    #300; // The gap lets the commit reach the system clock.
  endtask
endmodule // secc_host
`default_nettype wire
